// ### pkg/payload_pkg.sv
// Constants, field layout and capture record of the payload encoder.
// Assumes nothing beyond a SystemVerilog compiler.
package payload_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Payload geometry, bit offsets from the payload start
  localparam int unsigned PAYLOAD_W = 120;
  localparam int unsigned TS_OFS = 0;
  localparam int unsigned TS_W = 6;
  localparam int unsigned FS_OFS = 6;
  localparam int unsigned CAT_OFS = 8;
  localparam int unsigned EMG_OFS = 13;
  localparam int unsigned LAT_OFS = 16;
  localparam int unsigned LON_OFS = 40;
  localparam int unsigned POS_W = 24;
  localparam int unsigned GS_OFS = 64;
  localparam int unsigned GS_W = 8;
  localparam int unsigned ALT_OFS = 72;
  localparam int unsigned ALT_W = 14;
  localparam int unsigned VR_OFS = 86;
  localparam int unsigned VR_W = 9;
  localparam int unsigned TRK_OFS = 95;
  localparam int unsigned TRK_W = 9;
  localparam int unsigned SIL_OFS = 104;
  localparam int unsigned DAL_OFS = 106;
  localparam int unsigned NIC_OFS = 108;
  localparam int unsigned HPA_OFS = 112;
  localparam int unsigned VPA_OFS = 115;
  localparam int unsigned VEL_OFS = 117;
  localparam int unsigned RSV_OFS = 119;

  ////////////////////////////////////////////////////////////////////////
  // Code ranges and special values
  localparam int unsigned QCNT_W = 14;
  localparam int unsigned TS_MOD = 60;
  localparam logic [4:0] FS_MAX = 5'h02;
  localparam logic [4:0] CAT_MAX = 5'h0d;
  localparam logic [4:0] EMG_MAX = 5'h06;
  localparam logic [4:0] NIC_MAX = 5'h0c;
  localparam logic [23:0] POS_NOFIX = 24'hff_ffff;
  localparam logic [8:0] VR_ABSENT = 9'h100;

  ////////////////////////////////////////////////////////////////////////
  // Exponential coding: base widths, altitude offset, largest magnitudes
  localparam int unsigned GS_N = 6;
  localparam int unsigned VR_N = 6;
  localparam int unsigned ALT_N = 12;
  localparam int ALT_OFFSET_M = 320;
  localparam int unsigned GS_MAX = 952;
  localparam int unsigned VR_MAX = 952;
  localparam int unsigned ALT_MAX = 61432;

  ////////////////////////////////////////////////////////////////////////
  // Register map, reset values, latency
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PAY0 = 8'h10;
  localparam logic [7:0] REG_PAY1 = 8'h14;
  localparam logic [7:0] REG_PAY2 = 8'h18;
  localparam logic [7:0] REG_PAY3 = 8'h1c;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_NOFIX_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int unsigned LATENCY = 2;

  // One captured navigation solution, already sanitised
  typedef struct packed {
    logic [5:0] ts;
    logic [1:0] fs;
    logic [4:0] cat;
    logic [2:0] emg;
    logic nofix;
    logic [23:0] lat;
    logic [23:0] lon;
    logic [15:0] gs;
    logic [16:0] alt;
    logic vr_neg;
    logic [15:0] vr_mag;
    logic vr_absent;
    logic [8:0] trk;
    logic [1:0] sil;
    logic [1:0] dal;
    logic [3:0] nic;
    logic [2:0] hpa;
    logic [1:0] vpa;
    logic [1:0] vel;
  } cap_t;

  // Replaces a code above its defined range by zero (undefined)
  function automatic logic [4:0] clip(input logic [4:0] v, input logic [4:0] max);
    return (v > max) ? 5'h00 : v;
  endfunction : clip

endpackage : payload_pkg

// ### hdl/timestamp_wrap.sv
// Folds the quarter-second count of the hour into the 6-bit timestamp.
// Assumes a count of quarter seconds since the full hour.
`timescale 1ns/10ps

module timestamp_wrap (
  // Count in
  input wire logic [payload_pkg::QCNT_W-1:0] quarter_count,
  // Timestamp out, 0 to 59
  output logic [payload_pkg::TS_W-1:0] ts
);
  import payload_pkg::*;

  // Modulo keeps codes 60 to 63 out
  assign ts = TS_W'(32'(quarter_count) % TS_MOD);

endmodule : timestamp_wrap

// ### hdl/exp_encoder.sv
// Exponential encoder: 2-bit exponent ahead of an N-bit base.
// Assumes an unsigned magnitude; the sign is handled by the caller.
`timescale 1ns/10ps

module exp_encoder #(
  parameter int unsigned N = 6,
  parameter int unsigned VW = 16
) (
  // Magnitude in
  input wire logic [VW-1:0] value,
  // Exponent and base out
  output logic [N+1:0] code
);
  import payload_pkg::*;

  // Largest magnitude the all-ones code decodes to
  localparam int unsigned MAXV = 8 * ((2 ** (N + 1)) - 1) - (2 ** N);

  // Pick the exponent, then the shifted offset from its range start
  always_comb begin
    int unsigned v;
    int unsigned s;
    logic [1:0] e;
    v = 32'(value);
    s = 0;
    e = 2'h0;
    for (int i = 1; i < 4; i++) begin
      if (v >= 32'((2 ** (N + i)) - (2 ** N))) begin
        e = 2'(i);
        s = 32'((2 ** (N + i)) - (2 ** N));
      end
    end
    if (v > MAXV) begin
      code = '1;
    end else begin
      code = {e, N'((v - s) >> e)};
    end
  end

endmodule : exp_encoder

// ### hdl/traffic_payload_encoder.sv
// Conspicuity payload encoder with a classic Wishbone register slave.
// Assumes a navigation source and a Wishbone master on the same clock.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module traffic_payload_encoder (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Navigation strobe and fields
  input wire logic nav_valid,
  input wire logic [payload_pkg::QCNT_W-1:0] quarter_count,
  input wire logic [1:0] flight_state,
  input wire logic [4:0] category,
  input wire logic [2:0] emergency,
  input wire logic fix_valid,
  input wire logic signed [23:0] latitude,
  input wire logic signed [23:0] longitude,
  input wire logic [15:0] ground_speed,
  input wire logic signed [16:0] altitude,
  input wire logic signed [15:0] vertical_rate,
  input wire logic vrate_absent,
  input wire logic [15:0] ground_track,
  input wire logic [1:0] source_integrity,
  input wire logic [1:0] design_assurance,
  input wire logic [3:0] nav_integrity,
  input wire logic [2:0] horiz_accuracy,
  input wire logic [1:0] vert_accuracy,
  input wire logic [1:0] velocity_accuracy,
  // Packed payload
  output logic [payload_pkg::PAYLOAD_W-1:0] payload,
  output logic payload_valid,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);
  import payload_pkg::*;

  cap_t cap_d;
  cap_t cap_q;
  logic load_d;
  logic load_q;
  logic [PAYLOAD_W-1:0] payload_d;
  logic [PAYLOAD_W-1:0] payload_q;
  logic valid_d;
  logic valid_q;
  logic [15:0] count_d;
  logic [15:0] count_q;
  logic [1:0] ctrl_d;
  logic [1:0] ctrl_q;
  logic ack_d;
  logic ack_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic accept;
  logic [TS_W-1:0] ts_now;
  logic [16:0] alt_mag;
  logic [GS_W-1:0] gs_code;
  logic [ALT_W-1:0] alt_code;
  logic [VR_W-2:0] vr_code;

  ////////////////////////////////////////////////////////////////////////
  // Timestamp and encoders

  timestamp_wrap u_ts (
    .quarter_count(quarter_count),
    .ts(ts_now)
  );

  exp_encoder #(.N(GS_N), .VW(16)) u_gs (
    .value(cap_q.gs),
    .code(gs_code)
  );

  exp_encoder #(.N(ALT_N), .VW(17)) u_alt (
    .value(cap_q.alt),
    .code(alt_code)
  );

  exp_encoder #(.N(VR_N), .VW(16)) u_vr (
    .value(cap_q.vr_mag),
    .code(vr_code)
  );

  // Altitude shifted by the offset, negatives beyond it pinned to zero
  always_comb begin
    int a;
    a = int'(altitude) + ALT_OFFSET_M;
    alt_mag = (a < 0) ? 17'h0_0000 : 17'(a);
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture stage: freeze the solution at its strobe

  assign accept = nav_valid && ctrl_q[CTRL_EN_BIT];

  // Sanitised fields latched only on an accepted strobe
  always_comb begin
    cap_d = cap_q;
    load_d = accept;
    if (accept) begin
      cap_d.ts = ts_now;
      cap_d.fs = 2'(clip(5'(flight_state), FS_MAX));
      cap_d.cat = clip(category, CAT_MAX);
      cap_d.emg = 3'(clip(5'(emergency), EMG_MAX));
      cap_d.nofix = !fix_valid || ctrl_q[CTRL_NOFIX_BIT];
      cap_d.lat = latitude;
      cap_d.lon = longitude;
      cap_d.gs = ground_speed;
      cap_d.alt = alt_mag;
      cap_d.vr_neg = (vertical_rate < 0);
      cap_d.vr_mag = vertical_rate[15] ? 16'(-int'(vertical_rate)) : 16'(vertical_rate);
      cap_d.vr_absent = vrate_absent;
      cap_d.trk = ground_track[8:0];
      cap_d.sil = source_integrity;
      cap_d.dal = design_assurance;
      cap_d.nic = 4'(clip(5'(nav_integrity), NIC_MAX));
      cap_d.hpa = horiz_accuracy;
      cap_d.vpa = vert_accuracy;
      cap_d.vel = velocity_accuracy;
    end
  end

  // Capture registers
  always_ff @(posedge clock) begin
    if (srst) begin
      cap_q <= '0;
      load_q <= 1'b0;
    end else begin
      cap_q <= cap_d;
      load_q <= load_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Packing stage: one payload per captured solution

  always_comb begin
    payload_d = payload_q;
    valid_d = 1'b0;
    count_d = count_q;
    if (load_q) begin
      valid_d = 1'b1;
      count_d = count_q + 16'h0001;
      payload_d = '0;
      payload_d[TS_OFS +: TS_W] = cap_q.ts;
      payload_d[FS_OFS +: 2] = cap_q.fs;
      payload_d[CAT_OFS +: 5] = cap_q.cat;
      payload_d[EMG_OFS +: 3] = cap_q.emg;
      payload_d[LAT_OFS +: POS_W] = cap_q.nofix ? POS_NOFIX : cap_q.lat;
      payload_d[LON_OFS +: POS_W] = cap_q.nofix ? POS_NOFIX : cap_q.lon;
      payload_d[GS_OFS +: GS_W] = gs_code;
      payload_d[ALT_OFS +: ALT_W] = alt_code;
      if (cap_q.vr_absent) begin
        payload_d[VR_OFS +: VR_W] = VR_ABSENT;
      end else begin
        payload_d[VR_OFS +: VR_W] = {cap_q.vr_neg, vr_code};
      end
      payload_d[TRK_OFS +: TRK_W] = cap_q.trk;
      payload_d[SIL_OFS +: 2] = cap_q.sil;
      payload_d[DAL_OFS +: 2] = cap_q.dal;
      payload_d[NIC_OFS +: 4] = cap_q.nic;
      payload_d[HPA_OFS +: 3] = cap_q.hpa;
      payload_d[VPA_OFS +: 2] = cap_q.vpa;
      payload_d[VEL_OFS +: 2] = cap_q.vel;
      payload_d[RSV_OFS] = 1'b0;
    end
  end

  // Payload registers
  always_ff @(posedge clock) begin
    if (srst) begin
      payload_q <= '0;
      valid_q <= 1'b0;
      count_q <= 16'h0000;
    end else begin
      payload_q <= payload_d;
      valid_q <= valid_d;
      count_q <= count_d;
    end
  end

  assign payload = payload_q;
  assign payload_valid = valid_q;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request

  always_comb begin
    ack_d = wb_cyc && wb_stb && !ack_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    if (ack_d) begin
      case (wb_adr)
        REG_CTRL: rdata_d = {30'h0000_0000, ctrl_q};
        REG_STATUS: rdata_d = {10'h000, cap_q.ts, count_q};
        REG_PAY0: rdata_d = payload_q[31:0];
        REG_PAY1: rdata_d = payload_q[63:32];
        REG_PAY2: rdata_d = payload_q[95:64];
        REG_PAY3: rdata_d = {8'h00, payload_q[119:96]};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // Write lands at the edge the master sees ack
    if (wb_cyc && wb_stb && ack_q && wb_we && wb_sel[0] && wb_adr == REG_CTRL) begin
      ctrl_d = wb_dat_w[1:0];
    end
  end

  // Bus registers
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RESET;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Decoded magnitude of an exponential code
  function automatic int unsigned exp_dec(input logic [13:0] c, input int unsigned n);
    int unsigned e;
    int unsigned b;
    e = 32'(c >> n) & 32'h0000_0003;
    b = 32'(c) & ((32'h0000_0001 << n) - 1);
    return ((2 ** e) * ((2 ** n) + b)) - (2 ** n);
  endfunction : exp_dec

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  valid_latency_a: assert property (accept |-> ##2 valid_q)
    else $error("payload valid not two cycles after strobe");
  ts_range_a: assert property (valid_q |-> payload_q[TS_OFS +: TS_W] < 6'h3c)
    else $error("timestamp code out of range");
  ts_capture_a: assert property (accept |-> ##2 32'(payload_q[TS_OFS +: TS_W]) ==
      32'($past(quarter_count, 2)) % TS_MOD)
    else $error("timestamp not taken at strobe");
  flight_state_a: assert property (valid_q |-> payload_q[FS_OFS +: 2] != 2'h3)
    else $error("reserved flight state sent");
  category_code_a: assert property (valid_q |-> payload_q[CAT_OFS +: 5] <= CAT_MAX)
    else $error("reserved category sent");
  emergency_code_a: assert property (valid_q |-> payload_q[EMG_OFS +: 3] != 3'h7)
    else $error("reserved emergency sent");
  no_fix_a: assert property (accept && !fix_valid |-> ##2
      payload_q[LAT_OFS +: POS_W] == POS_NOFIX && payload_q[LON_OFS +: POS_W] == POS_NOFIX)
    else $error("no-fix position not all ones");
  position_copy_a: assert property (accept && fix_valid && !ctrl_q[CTRL_NOFIX_BIT] |-> ##2
      payload_q[LAT_OFS +: POS_W] == $past(latitude, 2))
    else $error("latitude not packed as given");
  speed_decode_a: assert property (valid_q && $past(cap_q.gs) <= GS_MAX |->
      exp_dec(14'(payload_q[GS_OFS +: GS_W]), GS_N) <= 32'($past(cap_q.gs)) &&
      32'($past(cap_q.gs)) - exp_dec(14'(payload_q[GS_OFS +: GS_W]), GS_N) <
      (32'h0000_0001 << payload_q[GS_OFS + GS_N +: 2]))
    else $error("ground speed code does not decode back");
  speed_clamp_a: assert property (valid_q && $past(cap_q.gs) > GS_MAX |->
      payload_q[GS_OFS +: GS_W] == 8'hff)
    else $error("over-range speed not clamped");
  vrate_zero_a: assert property (accept && vertical_rate == 0 && !vrate_absent |-> ##2
      payload_q[VR_OFS +: VR_W] == 9'h000)
    else $error("zero rate not encoded as plus zero");
  vrate_sign_a: assert property (accept && vertical_rate < 0 && !vrate_absent |-> ##2
      payload_q[VR_OFS + VR_W - 1])
    else $error("negative rate without sign bit");
  reserved_bit_a: assert property (valid_q |-> !payload_q[RSV_OFS])
    else $error("reserved bit set");

  no_fix_c: cover property (accept && !fix_valid ##2 valid_q);
  rate_absent_c: cover property (accept && vrate_absent ##2 valid_q);
  speed_clamp_c: cover property (valid_q && payload_q[GS_OFS +: GS_W] == 8'hff);
  back_to_back_c: cover property (accept ##1 accept ##1 valid_q ##1 valid_q);

endmodule : traffic_payload_encoder

// ### tb/frame_sink.sv
// Framing stage model: takes every payload on its valid pulse.
// Assumes the encoder clock and a one-cycle payload_valid pulse.
`timescale 1ns/10ps

module frame_sink (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Payload from the encoder
  input wire logic [payload_pkg::PAYLOAD_W-1:0] payload,
  input wire logic payload_valid
);
  import payload_pkg::*;

  int edge_n = 0;
  int rx_count = 0;
  logic [PAYLOAD_W-1:0] rx_pay [0:127];
  int rx_edge [0:127];

  ////////////////////////////////////////////////////////////////////////
  // Edge stamp and capture of each delivered payload
  always @(posedge clock) begin
    edge_n <= edge_n + 1;
    if (srst) begin
      rx_count <= 0;
    end else if (payload_valid === 1'b1) begin
      rx_pay[rx_count] <= payload;
      rx_edge[rx_count] <= edge_n;
      rx_count <= rx_count + 1;
    end
  end

endmodule : frame_sink

// ### tb/traffic_payload_encoder_tb_top.sv
// Self-checking bench for the payload encoder and its register slave.
// Assumes payload_pkg and the frame_sink model are compiled first.
`timescale 1ns/10ps

module traffic_payload_encoder_tb_top;
  import payload_pkg::*;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic nav_valid = 1'b0;
  logic [QCNT_W-1:0] quarter_count = '0;
  logic [1:0] flight_state = '0;
  logic [4:0] category = '0;
  logic [2:0] emergency = '0;
  logic fix_valid = 1'b1;
  logic signed [23:0] latitude = '0;
  logic signed [23:0] longitude = '0;
  logic [15:0] ground_speed = '0;
  logic signed [16:0] altitude = '0;
  logic signed [15:0] vertical_rate = '0;
  logic vrate_absent = 1'b0;
  logic [15:0] ground_track = '0;
  logic [1:0] source_integrity = '0;
  logic [1:0] design_assurance = '0;
  logic [3:0] nav_integrity = '0;
  logic [2:0] horiz_accuracy = '0;
  logic [1:0] vert_accuracy = '0;
  logic [1:0] velocity_accuracy = '0;
  logic [PAYLOAD_W-1:0] payload;
  logic payload_valid;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = '0;
  logic [3:0] wb_sel = '0;
  logic [31:0] wb_dat_w = '0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic [31:0] rd;
  logic [PAYLOAD_W-1:0] last_exp = '0;
  logic [PAYLOAD_W-1:0] exp_q [$];
  int edge_q [$];
  logic en_on = 1'b1;
  logic force_nf = 1'b0;
  int done_n = 0;
  int err_count = 0;
  int comparisons = 0;

  traffic_payload_encoder traffic_payload_encoder_inst (.clock(clock), .srst(srst), .nav_valid(nav_valid),
    .quarter_count(quarter_count), .flight_state(flight_state), .category(category), .emergency(emergency),
    .fix_valid(fix_valid), .latitude(latitude), .longitude(longitude), .ground_speed(ground_speed),
    .altitude(altitude), .vertical_rate(vertical_rate), .vrate_absent(vrate_absent),
    .ground_track(ground_track), .source_integrity(source_integrity), .design_assurance(design_assurance),
    .nav_integrity(nav_integrity), .horiz_accuracy(horiz_accuracy), .vert_accuracy(vert_accuracy),
    .velocity_accuracy(velocity_accuracy), .payload(payload), .payload_valid(payload_valid),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

  frame_sink frame_sink_inst (.clock(clock), .srst(srst), .payload(payload), .payload_valid(payload_valid));

  // 20 MHz clock
  always #25 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  // Reference exponential code of a magnitude
  function automatic int exp_enc(input int v, input int n);
    int e;
    e = 0;
    if (v >= 8 * ((2 << n) - 1) - (1 << n)) return (4 << n) - 1;
    for (int i = 1; i < 4; i++) if (v >= (1 << (n + i)) - (1 << n)) e = i;
    return (e << n) | ((v - ((1 << (n + e)) - (1 << n))) >> e);
  endfunction : exp_enc

  // Reference payload from the inputs now on the pins
  function automatic logic [PAYLOAD_W-1:0] expect_pay();
    logic [PAYLOAD_W-1:0] p;
    int a;
    int m;
    p = '0;
    a = int'(altitude) + ALT_OFFSET_M;
    m = int'(vertical_rate);
    p[TS_OFS +: TS_W] = 6'(quarter_count % TS_MOD);
    p[FS_OFS +: 2] = (flight_state == 2'h3) ? 2'h0 : flight_state;
    p[CAT_OFS +: 5] = (category > 5'h0d) ? 5'h00 : category;
    p[EMG_OFS +: 3] = (emergency == 3'h7) ? 3'h0 : emergency;
    p[LAT_OFS +: POS_W] = (fix_valid && !force_nf) ? latitude : POS_NOFIX;
    p[LON_OFS +: POS_W] = (fix_valid && !force_nf) ? longitude : POS_NOFIX;
    p[GS_OFS +: GS_W] = 8'(exp_enc(int'(ground_speed), GS_N));
    p[ALT_OFS +: ALT_W] = 14'((a < 0) ? 0 : exp_enc(a, ALT_N));
    p[VR_OFS +: VR_W] = vrate_absent ? VR_ABSENT : {m < 0, 8'(exp_enc((m < 0) ? -m : m, VR_N))};
    p[TRK_OFS +: TRK_W] = ground_track[8:0];
    p[SIL_OFS +: 2] = source_integrity;
    p[DAL_OFS +: 2] = design_assurance;
    p[NIC_OFS +: 4] = (nav_integrity > 4'hc) ? 4'h0 : nav_integrity;
    p[HPA_OFS +: 3] = horiz_accuracy;
    p[VPA_OFS +: 2] = vert_accuracy;
    p[VEL_OFS +: 2] = velocity_accuracy;
    return p;
  endfunction : expect_pay

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per kind of result
  task automatic chk_pay(input logic [PAYLOAD_W-1:0] got, input logic [PAYLOAD_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: payload %h expected %h", $time, got, exp);
    end
  endtask : chk_pay

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: bus word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_num(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_count++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_num

  // Classic single Wishbone cycle; read data lands in rd
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dw);
    int t;
    t = 0;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat_w <= dw;
    do begin
      @(posedge clock);
      t++;
    end while (wb_ack !== 1'b1 && t < 20);
    rd = wb_dat_r;
    if (t >= 20) chk_num(t, 0);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  // n strobes back to back; count moves on between captures only, so the caller may set it next
  task automatic fire(input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge clock);
      if (i > 0 && en_on) begin
        exp_q.push_back(expect_pay());
        edge_q.push_back(frame_sink_inst.edge_n);
      end
      if (i > 0 && i < n) quarter_count <= (quarter_count == 14'h383f) ? '0 : quarter_count + 14'h0001;
      nav_valid <= (i < n);
    end
  endtask : fire

  // Waits for all expected payloads and checks content and latency
  task automatic drain();
    int t;
    t = 0;
    while (frame_sink_inst.rx_count < done_n + exp_q.size() && t < 20) begin
      @(posedge clock);
      t++;
    end
    repeat (3) @(posedge clock);
    chk_num(frame_sink_inst.rx_count, done_n + exp_q.size());
    while (exp_q.size() > 0) begin
      last_exp = exp_q.pop_front();
      chk_pay(frame_sink_inst.rx_pay[done_n], last_exp);
      chk_num(frame_sink_inst.rx_edge[done_n] - edge_q.pop_front(), int'(LATENCY));
      done_n++;
    end
    done_n = frame_sink_inst.rx_count;
  endtask : drain

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk_pay(payload, '0);
    wb_xfer(1'b0, REG_CTRL, 32'h0);
    chk_word(rd, 32'h0000_0001);
    wb_xfer(1'b1, 8'h08, 32'hffff_ffff);
    wb_xfer(1'b0, 8'h08, 32'h0);
    chk_word(rd, 32'h0000_0000);
  endtask : t_reset

  task automatic t_fields();
    quarter_count <= 14'h0ef3;
    flight_state <= 2'h2;
    category <= 5'h0d;
    emergency <= 3'h6;
    latitude <= 24'hed_2979;
    longitude <= 24'h12_3456;
    ground_speed <= 16'h01e0;
    altitude <= 17'h0_03e8;
    vertical_rate <= 16'hffb0;
    ground_track <= 16'h0205;
    source_integrity <= 2'h3;
    design_assurance <= 2'h2;
    nav_integrity <= 4'hc;
    horiz_accuracy <= 3'h7;
    vert_accuracy <= 2'h3;
    velocity_accuracy <= 2'h1;
    fire(1);
    drain();
  endtask : t_fields

  task automatic t_exp();
    int gs_t[8] = '{0, 1, 3, 480, 952, 953, 2000, 65535};
    int alt_t[8] = '{-320, 0, 1000, 61112, -400, -319, 61113, 65535};
    int vr_t[8] = '{0, 1, -1, 80, -80, 952, -952, -32768};
    for (int i = 0; i < 8; i++) begin
      ground_speed <= 16'(gs_t[i]);
      altitude <= 17'(alt_t[i]);
      vertical_rate <= 16'(vr_t[i]);
      fire(1);
    end
    drain();
  endtask : t_exp

  task automatic t_codes();
    int cat_t[8] = '{0, 1, 12, 13, 14, 20, 30, 31};
    for (int i = 0; i < 8; i++) begin
      flight_state <= 2'(i);
      category <= 5'(cat_t[i]);
      emergency <= 3'(i);
      nav_integrity <= 4'(i * 2 + 1);
      quarter_count <= 14'(i * 2057);
      fix_valid <= 1'(i % 2);
      vrate_absent <= (i == 3);
      ground_track <= 16'(i * 300 + 7);
      horiz_accuracy <= 3'(i);
      source_integrity <= 2'(i);
      fire(1);
    end
    drain();
  endtask : t_codes

  task automatic t_burst();
    quarter_count <= 14'h383e;
    fire(4);
    drain();
  endtask : t_burst

  task automatic t_ctrl();
    wb_xfer(1'b1, REG_CTRL, 32'h0);
    en_on = 1'b0;
    fire(2);
    drain();
    wb_xfer(1'b1, REG_CTRL, 32'h0000_0003);
    en_on = 1'b1;
    force_nf = 1'b1;
    fix_valid <= 1'b1;
    fire(1);
    drain();
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    chk_word(rd, {10'h000, last_exp[TS_OFS +: TS_W], 16'(done_n)});
    wb_xfer(1'b1, REG_PAY0, 32'hffff_ffff);
    for (int k = 0; k < 4; k++) begin
      wb_xfer(1'b0, 8'(REG_PAY0 + 8'(4 * k)), 32'h0);
      chk_word(rd, 32'(last_exp >> (32 * k)));
    end
    wb_xfer(1'b1, REG_CTRL, 32'h0000_0001);
    force_nf = 1'b0;
  endtask : t_ctrl

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic give_verdict();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence after a five-cycle reset
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_fields();
    t_exp();
    t_codes();
    t_burst();
    t_ctrl();
    give_verdict();
  end

  // Watchdog, far beyond the roughly 120 cycles needed
  initial begin
    #1_000_000;
    err_count++;
    give_verdict();
  end

endmodule : traffic_payload_encoder_tb_top
